// [pfe_defs.svh]
`ifndef PFE_DEFS_SVH
`define PFE_DEFS_SVH

// register byte offsets
`define PFE_OFF_CTRL 8'h00
`define PFE_OFF_STATE 8'h04
`define PFE_OFF_ACC 8'h08
`define PFE_OFF_STATUS 8'h0C
`define PFE_OFF_INDEX 8'h10
`define PFE_OFF_MODE 8'h14
`define PFE_OFF_PC 8'h18
`define PFE_OFF_TICK 8'h1C
`define PFE_OFF_SHD_LO 8'h20
`define PFE_OFF_SHD_HI 8'h24
`define PFE_OFF_STACK_TOP 8'h28

// control fields
`define PFE_CTRL_RUN 0
`define PFE_CTRL_WAKE 1
`define PFE_CTRL_PSC_GUARD 2

// status register fields
`define PFE_ST_CARRY 0
`define PFE_ST_ZERO 2
`define PFE_ST_HALTED 3
`define PFE_ST_EXPIRY 4
`define PFE_ST_PAGE_LSB 5

// file addresses seen by bit operations
`define PFE_FILE_PC 5'h02
`define PFE_FILE_STATUS 5'h03

// reset values
`define PFE_RST_STATUS 8'h18
`define PFE_RST_PC 12'hFFF

// cycle counts
`define PFE_CYC_BRANCH 3
`define PFE_CYC_SKIP 2
`define PFE_CYC_CODE_FETCH 4

`endif

// [pfe_exec.sv]
// Functional notes
// - call pushes pc+1, loads page and operand
// - direct jump loads nine bits plus page
// - subroutine exit pops counter, three cycles
// - paged exit also restores page bits
// - interrupt exit restores shadow state except expiry/halted
// - tick-add variant adds accumulator to ticks
// - literal exit loads accumulator and pops
// - data-segment select writes index bits 6:4
// - code-segment select writes status bits 7:5
// - code fetch reads mode:acc address, four cycles
// - halt clears guard, sets expiry, stops
// - power-down clears halted flag, maybe prescaler
// - all-zero opcode is a one-cycle nop
// - carry lives in status bit 0
// - zero lives in status bit 2
// - writing or adding to pc jumps, three cycles
// - skip tests take one or two cycles
// - pc bit 0 testable by skip tests
// - immediate mode load, one cycle
`timescale 1ns/1ps
`include "pfe_defs.svh"

module pfe_exec #(
	parameter int STACK_DEPTH = 8
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	// instruction memory, combinational read
	output logic [11:0] imem_addr,
	input wire logic [11:0] imem_data,
	// core side effects
	output logic guard_clear,
	output logic prescaler_clear,
	output logic asleep,
	// axi4-lite write address
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read address
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// axi4-lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	localparam int SPW = $clog2(STACK_DEPTH);

	initial begin
		if (STACK_DEPTH < 2 || (1 << SPW) != STACK_DEPTH) begin
			$error("STACK_DEPTH must be a power of two, at least 2");
		end
	end

	pfe_pkg::pfe_arch_s arch;
	pfe_pkg::pfe_arch_s shadow;
	pfe_pkg::pfe_arch_s next_arch;
	pfe_pkg::pfe_phase_e phase;
	logic [11:0] stack [STACK_DEPTH];
	logic [SPW-1:0] sp;
	logic [1:0] cnt;
	logic [7:0] tick;
	logic run;
	logic psc_guard;
	logic wake_hit;

	// decode
	wire logic [11:0] ir = imem_data;
	wire logic [7:0] k8 = ir[7:0];
	wire logic [4:0] fr = ir[4:0];
	wire logic [2:0] bsel = ir[7:5];
	wire logic [2:0] page = arch.status[7:5];
	wire logic [11:0] tos = stack[sp - 1'b1];
	wire logic exec_en = run && phase == pfe_pkg::PFE_EXEC;
	wire logic op_call = ir[11:8] == 4'b1001;
	wire logic op_jump = ir[11:9] == 3'b101;
	wire logic op_ret = ir == 12'h00C;
	wire logic op_paged_subroutine_exit = ir == 12'h00D;
	wire logic op_interrupt_exit = ir == 12'h00E;
	wire logic op_interrupt_exit_tick_add = ir == 12'h00F;
	wire logic op_literal_subroutine_exit = ir[11:8] == 4'b1000;
	wire logic op_bank = ir[11:3] == 9'b0000_0001_1;
	wire logic op_page = ir[11:3] == 9'b0000_0001_0;
	wire logic op_cfetch = ir == 12'h041;
	wire logic op_sleep = ir == 12'h003;
	wire logic op_mode_imm = ir[11:4] == 8'h05;
	wire logic op_mode_acc = ir == 12'h043;
	wire logic op_mov_fr = ir[11:5] == 7'b0000_001;
	wire logic op_add_fr = ir[11:5] == 7'b0001_111;
	wire logic op_clrb = ir[11:8] == 4'b0100;
	wire logic op_setb = ir[11:8] == 4'b0101;
	wire logic op_snb = ir[11:8] == 4'b0110;
	wire logic op_sb = ir[11:8] == 4'b0111;
	wire logic fr_pc = fr == `PFE_FILE_PC;
	wire logic fr_st = fr == `PFE_FILE_STATUS;
	// status and pc low byte are the only files held here
	wire logic [7:0] fr_val = fr_pc ? arch.pc[7:0] : arch.status;
	wire logic tbit = fr_val[bsel];
	wire logic fr_ok = fr_pc || fr_st;
	wire logic [7:0] pc_inc8 = 8'(arch.pc[7:0] + 8'h01);

	logic push;
	logic pop;
	logic [1:0] waits;
	logic go_fetch;
	logic go_sleep;
	logic tick_add;
	logic [7:0] bit_new;

	always_comb begin
		next_arch = arch;
		next_arch.pc = 12'(arch.pc + 12'h001);
		push = 1'b0;
		pop = 1'b0;
		waits = 2'd0;
		go_fetch = 1'b0;
		go_sleep = 1'b0;
		tick_add = 1'b0;
		bit_new = fr_val;
		bit_new[bsel] = op_setb;
		if (op_call) begin
			push = 1'b1;
			next_arch.pc = {page, 1'b0, k8};
			waits = 2'(`PFE_CYC_BRANCH - 1);
		end else if (op_jump) begin
			next_arch.pc = {page, ir[8:0]};
			waits = 2'(`PFE_CYC_BRANCH - 1);
		end else if (op_ret || op_paged_subroutine_exit || op_literal_subroutine_exit) begin
			pop = 1'b1;
			next_arch.pc = tos;
			waits = 2'(`PFE_CYC_BRANCH - 1);
			if (op_paged_subroutine_exit) begin
				next_arch.status[7:5] = tos[11:9];
			end
			if (op_literal_subroutine_exit) begin
				next_arch.acc = k8;
			end
		end else if (op_interrupt_exit || op_interrupt_exit_tick_add) begin
			next_arch = shadow;
			next_arch.status[`PFE_ST_EXPIRY] = arch.status[`PFE_ST_EXPIRY];
			next_arch.status[`PFE_ST_HALTED] = arch.status[`PFE_ST_HALTED];
			waits = 2'(`PFE_CYC_BRANCH - 1);
			tick_add = op_interrupt_exit_tick_add;
		end else if (op_bank) begin
			next_arch.index[6:4] = ir[2:0];
		end else if (op_page) begin
			next_arch.status[7:5] = ir[2:0];
		end else if (op_cfetch) begin
			go_fetch = 1'b1;
		end else if (op_sleep) begin
			go_sleep = 1'b1;
			next_arch.status[`PFE_ST_EXPIRY] = 1'b1;
			next_arch.status[`PFE_ST_HALTED] = 1'b0;
		end else if (op_mode_imm) begin
			next_arch.mode = ir[3:0];
		end else if (op_mode_acc) begin
			next_arch.mode = arch.acc[3:0];
		end else if ((op_mov_fr || op_add_fr) && fr_pc) begin
			next_arch.pc = {page, 1'b0, op_mov_fr ? arch.acc : 8'(pc_inc8 + arch.acc)};
			waits = 2'(`PFE_CYC_BRANCH - 1);
		end else if ((op_mov_fr || op_add_fr) && fr_st) begin
			next_arch.status = op_mov_fr ? arch.acc : 8'(arch.status + arch.acc);
		end else if ((op_clrb || op_setb) && fr_st) begin
			next_arch.status = bit_new;
		end else if ((op_clrb || op_setb) && fr_pc) begin
			next_arch.pc = {arch.pc[11:8], bit_new};
			waits = 2'(`PFE_CYC_BRANCH - 1);
		end else if ((op_snb || op_sb) && fr_ok) begin
			if (tbit == op_sb) begin
				next_arch.pc = 12'(arch.pc + 12'h002);
				waits = 2'(`PFE_CYC_SKIP - 1);
			end
		end
	end

	// sequencer
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			phase <= pfe_pkg::PFE_EXEC;
			cnt <= 2'd0;
		end else begin
			case (phase)
				pfe_pkg::PFE_EXEC: begin
					if (exec_en && go_sleep) begin
						phase <= pfe_pkg::PFE_ASLEEP;
					end else if (exec_en && go_fetch) begin
						phase <= pfe_pkg::PFE_FETCH;
						cnt <= 2'(`PFE_CYC_CODE_FETCH - 1);
					end else if (exec_en && waits != 2'd0) begin
						phase <= pfe_pkg::PFE_WAIT;
						cnt <= waits;
					end
				end
				pfe_pkg::PFE_WAIT, pfe_pkg::PFE_FETCH: begin
					cnt <= cnt - 2'd1;
					if (cnt == 2'd1) begin
						phase <= pfe_pkg::PFE_EXEC;
					end
				end
				// only a wake write leaves power-down, never cuts bubbles
				pfe_pkg::PFE_ASLEEP: begin
					if (wake_hit) begin
						phase <= pfe_pkg::PFE_EXEC;
					end
				end
				default: begin
					phase <= pfe_pkg::PFE_EXEC;
				end
			endcase
		end
	end

	// word lands on the last fetch cycle
	wire logic fetch_done = phase == pfe_pkg::PFE_FETCH && cnt == 2'd1;
	assign imem_addr = phase == pfe_pkg::PFE_FETCH ? {arch.mode, arch.acc} : arch.pc;
	assign asleep = phase == pfe_pkg::PFE_ASLEEP;

	// register bus
	logic aw_hold;
	logic w_hold;
	pfe_pkg::pfe_wreq_s wreq;
	wire logic wr_fire = aw_hold && w_hold && !s_axi_bvalid;
	wire logic [31:0] wmask = {{8{wreq.strb[3]}}, {8{wreq.strb[2]}}, {8{wreq.strb[1]}}, {8{wreq.strb[0]}}};
	wire logic [31:0] state_word = {28'h000_0000, 1'b1, phase, asleep};

	function automatic logic [31:0] reg_read(input logic [7:0] a);
		case (a)
			`PFE_OFF_CTRL: reg_read = {29'h0, psc_guard, 1'b0, run};
			`PFE_OFF_STATE: reg_read = state_word;
			`PFE_OFF_ACC: reg_read = {24'h0, arch.acc};
			`PFE_OFF_STATUS: reg_read = {24'h0, arch.status};
			`PFE_OFF_INDEX: reg_read = {24'h0, arch.index};
			`PFE_OFF_MODE: reg_read = {28'h0, arch.mode};
			`PFE_OFF_PC: reg_read = {20'h0, arch.pc};
			`PFE_OFF_TICK: reg_read = {24'h0, tick};
			`PFE_OFF_SHD_LO: reg_read = {8'h0, shadow.index, shadow.status, shadow.acc};
			`PFE_OFF_SHD_HI: reg_read = {16'h0, shadow.pc, shadow.mode};
			`PFE_OFF_STACK_TOP: reg_read = {20'h0, tos};
			default: reg_read = 32'h0000_0000;
		endcase
	endfunction

	function automatic logic reg_mapped(input logic [7:0] a);
		reg_mapped = a[1:0] == 2'b00 && a <= `PFE_OFF_STACK_TOP;
	endfunction

	logic [31:0] wmerged;
	// always_comb also wakes on the state that reg_read reads
	always_comb begin
		wmerged = (reg_read(wreq.addr) & ~wmask) | (wreq.data & wmask);
	end
	wire logic wr_ok = reg_mapped(wreq.addr);
	// architectural state is only writable while stopped
	wire logic sw_arch = wr_fire && !run;
	assign wake_hit = wr_fire && wreq.addr == `PFE_OFF_CTRL && wreq.strb[0] && wreq.data[`PFE_CTRL_WAKE];

	assign s_axi_awready = !aw_hold && !s_axi_bvalid;
	assign s_axi_wready = !w_hold && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			aw_hold <= 1'b0;
			w_hold <= 1'b0;
			wreq <= '0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold <= 1'b1;
				wreq.addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold <= 1'b1;
				wreq.data <= s_axi_wdata;
				wreq.strb <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_hold <= 1'b0;
				w_hold <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? 2'b00 : 2'b10;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= 2'b00;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= reg_read(s_axi_araddr);
			s_axi_rresp <= reg_mapped(s_axi_araddr) ? 2'b00 : 2'b10;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// control register
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			run <= 1'b0;
			psc_guard <= 1'b0;
		end else if (wr_fire && wreq.addr == `PFE_OFF_CTRL) begin
			run <= wmerged[`PFE_CTRL_RUN];
			psc_guard <= wmerged[`PFE_CTRL_PSC_GUARD];
		end
	end

	// architectural state
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			arch.pc <= `PFE_RST_PC;
			arch.mode <= 4'h0;
			arch.index <= 8'h00;
			arch.status <= `PFE_RST_STATUS;
			arch.acc <= 8'h00;
		end else if (sw_arch) begin
			case (wreq.addr)
				`PFE_OFF_ACC: arch.acc <= wmerged[7:0];
				`PFE_OFF_STATUS: arch.status <= wmerged[7:0];
				`PFE_OFF_INDEX: arch.index <= wmerged[7:0];
				`PFE_OFF_MODE: arch.mode <= wmerged[3:0];
				`PFE_OFF_PC: arch.pc <= wmerged[11:0];
				default: arch <= arch;
			endcase
		end else if (exec_en) begin
			arch <= next_arch;
		end else if (run && fetch_done) begin
			{arch.mode, arch.acc} <= imem_data;
		end
	end

	// shadow copy, loaded by software only
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			shadow <= '0;
		end else if (wr_fire && wreq.addr == `PFE_OFF_SHD_LO) begin
			{shadow.index, shadow.status, shadow.acc} <= wmerged[23:0];
		end else if (wr_fire && wreq.addr == `PFE_OFF_SHD_HI) begin
			{shadow.pc, shadow.mode} <= wmerged[15:0];
		end
	end

	// stack and tick counter
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			sp <= '0;
			tick <= 8'h00;
		end else begin
			if (exec_en && push) begin
				sp <= sp + 1'b1;
			end else if (exec_en && pop) begin
				sp <= sp - 1'b1;
			end
			if (wr_fire && wreq.addr == `PFE_OFF_TICK) begin
				tick <= wmerged[7:0];
			end else if (exec_en && tick_add) begin
				tick <= 8'(tick + arch.acc);
			end
		end
	end

	// stack overflow wraps silently, as a small hardware stack does
	always_ff @(posedge clk_sys) begin
		if (exec_en && push) begin
			stack[sp] <= 12'(arch.pc + 12'h001);
		end
	end

	// power-down side effects
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			guard_clear <= 1'b0;
			prescaler_clear <= 1'b0;
		end else begin
			guard_clear <= exec_en && go_sleep;
			// prescaler only when assigned to guard
			prescaler_clear <= exec_en && go_sleep && psc_guard;
		end
	end

endmodule

// [pfe_exec_props.sv]
`timescale 1ns/1ps
`include "pfe_defs.svh"
module pfe_exec_props (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	// core side effects
	input wire logic guard_clear,
	input wire logic prescaler_clear,
	input wire logic asleep,
	// register bus
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	sequence s_aw_w_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_bad_read;
		s_axi_arvalid && s_axi_arready && (s_axi_araddr > `PFE_OFF_STACK_TOP || s_axi_araddr[1:0] != 2'b00);
	endsequence
	// held for one cycle, then answered
	a_write_answer: assert property (s_aw_w_taken |-> ##2 s_axi_bvalid) else $error("write answer late");
	a_bvalid_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid lingers");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
	a_rvalid_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("rvalid lingers");
	a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
	a_bad_read_err: assert property (s_bad_read |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0000_0000)
		else $error("bad read not refused");
	a_guard_pulse: assert property (guard_clear |=> !guard_clear) else $error("guard clear too long");
	a_psc_with_guard: assert property (prescaler_clear |-> guard_clear) else $error("prescaler clear alone");
	a_guard_asleep: assert property (guard_clear |-> ##[0:1] asleep) else $error("halt did not sleep");
	// only a wake write may end power-down; its answer rises at the same edge
	a_sleep_holds: assert property ($fell(asleep) |-> s_axi_bvalid)
		else $error("woke without write");
endmodule
bind pfe_exec pfe_exec_props u_props (.*);

// [pfe_exec_test.sv]
`timescale 1ns/1ps
`include "pfe_defs.svh"
module pfe_exec_test;
	typedef struct packed {
		logic [11:0] i0;
		logic [11:0] a1;
		logic [11:0] i1;
		logic [7:0] st;
		logic [11:0] pc;
		logic [7:0] off;
		logic [11:0] val;
	} pfe_row_s;
	logic clk_sys, rstn, guard_clear, prescaler_clear, asleep, gseen, pseen;
	logic [11:0] imem_addr, imem_data;
	logic [11:0] mem [0:4095];
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	int err_count = 0;
	int checks = 0;
	// pc starts at 010, acc 5a, mode 0, index 0; the rest of memory jumps to its own offset in the current page
	pfe_row_s rows [21] = '{
		'{12'h000, 12'h020, 12'hA20, 8'h00, 12'h011, `PFE_OFF_ACC, 12'h05A},
		'{12'hBF3, 12'h020, 12'hA20, 8'h20, 12'h3F3, `PFE_OFF_STATUS, 12'h020},
		'{12'h955, 12'h020, 12'hA20, 8'h00, 12'h055, `PFE_OFF_STACK_TOP, 12'h011},
		'{12'h920, 12'h020, 12'h00C, 8'h00, 12'h011, `PFE_OFF_ACC, 12'h05A},
		'{12'h920, 12'h220, 12'h00D, 8'h20, 12'h011, `PFE_OFF_STATUS, 12'h000},
		'{12'h920, 12'h020, 12'h83C, 8'h00, 12'h011, `PFE_OFF_ACC, 12'h03C},
		'{12'h00E, 12'h020, 12'hA20, 8'h00, 12'h033, `PFE_OFF_ACC, 12'h077},
		'{12'h00F, 12'h020, 12'hA20, 8'h00, 12'h033, `PFE_OFF_TICK, 12'h05A},
		'{12'h00F, 12'h020, 12'hA20, 8'h00, 12'h033, `PFE_OFF_INDEX, 12'h012},
		'{12'h01D, 12'h020, 12'hA20, 8'h00, 12'h011, `PFE_OFF_INDEX, 12'h050},
		'{12'h013, 12'h020, 12'hA20, 8'h00, 12'h611, `PFE_OFF_STATUS, 12'h060},
		'{12'h041, 12'h05A, 12'h3C7, 8'h00, 12'h011, `PFE_OFF_ACC, 12'h0C7},
		'{12'h057, 12'h020, 12'hA20, 8'h00, 12'h011, `PFE_OFF_MODE, 12'h007},
		'{12'h022, 12'h020, 12'hA20, 8'h00, 12'h05A, `PFE_OFF_ACC, 12'h05A},
		'{12'h1E2, 12'h020, 12'hA20, 8'h00, 12'h06B, `PFE_OFF_ACC, 12'h05A},
		'{12'h403, 12'h020, 12'hA20, 8'h01, 12'h011, `PFE_OFF_STATUS, 12'h000},
		'{12'h443, 12'h020, 12'hA20, 8'h04, 12'h011, `PFE_OFF_STATUS, 12'h000},
		'{12'h703, 12'h020, 12'hA20, 8'h01, 12'h012, `PFE_OFF_STATUS, 12'h001},
		'{12'h703, 12'h020, 12'hA20, 8'h00, 12'h011, `PFE_OFF_STATUS, 12'h000},
		'{12'h602, 12'h020, 12'hA20, 8'h00, 12'h012, `PFE_OFF_ACC, 12'h05A},
		'{12'hA20, 12'h020, 12'h1E3, 8'h00, 12'h421, `PFE_OFF_STATUS, 12'h05A}
	};

	pfe_exec dut (.*);
	assign imem_data = mem[imem_addr];

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	always @(posedge clk_sys) begin
		if (!rstn) begin
			gseen <= 1'b0;
			pseen <= 1'b0;
		end else begin
			if (guard_clear) gseen <= 1'b1;
			if (prescaler_clear) pseen <= 1'b1;
		end
	end

	function automatic logic [11:0] self_jmp(input logic [11:0] a);
		return {3'b101, a[8:0]};
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
		chk({30'h0, got}, {30'h0, exp});
	endtask

	// valid and payload held until the ready edge; bready stays high
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		r = s_axi_bresp;
	endtask

	task automatic rd(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		rd(a);
		chk(d, exp);
	endtask

	task automatic run_row(input pfe_row_s w);
		wr(`PFE_OFF_CTRL, 32'h0000_0000);
		wr(`PFE_OFF_PC, 32'h0000_0010);
		wr(`PFE_OFF_STATUS, {24'h00_0000, w.st});
		wr(`PFE_OFF_ACC, 32'h0000_005A);
		wr(`PFE_OFF_MODE, 32'h0000_0000);
		wr(`PFE_OFF_INDEX, 32'h0000_0000);
		mem[16] = w.i0;
		mem[w.a1] = w.i1;
		wr(`PFE_OFF_CTRL, 32'h0000_0001);
		repeat (20) @(posedge clk_sys);
		wr(`PFE_OFF_CTRL, 32'h0000_0000);
		rchk(`PFE_OFF_PC, {20'h0_0000, w.pc});
		rchk(w.off, {20'h0_0000, w.val});
		mem[16] = self_jmp(12'h010);
		mem[w.a1] = self_jmp(w.a1);
	endtask

	task automatic wrap_up;
		$display("checks=%0d err_count=%0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// about a thousand cycles are expected
	initial begin
		#100000;
		err_count++;
		wrap_up;
	end

	initial begin
		rstn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0000_0000_0000;
		{s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3F;
		for (int i = 0; i < 4096; i++) mem[i] = self_jmp(i[11:0]);
		repeat (4) @(posedge clk_sys);
		rstn <= 1'b1;
		rchk(`PFE_OFF_STATUS, 32'h0000_0018);
		rchk(`PFE_OFF_PC, 32'h0000_0FFF);
		rd(8'h3C);
		chk_resp(r, 2'b10);
		chk(d, 32'h0000_0000);
		wr(8'h3C, 32'h0000_0001);
		chk_resp(r, 2'b10);
		wr(`PFE_OFF_SHD_LO, 32'h0012_0077);
		wr(`PFE_OFF_SHD_HI, 32'h0000_0333);
		chk_resp(r, 2'b00);
		foreach (rows[i]) run_row(rows[i]);
		wr(`PFE_OFF_STATUS, 32'h0000_0000);
		wr(`PFE_OFF_PC, 32'h0000_0010);
		mem[16] = 12'h003;
		wr(`PFE_OFF_CTRL, 32'h0000_0005);
		for (int n = 0; n < 50 && !asleep; n++) @(posedge clk_sys);
		rchk(`PFE_OFF_STATE, 32'h0000_000F);
		rchk(`PFE_OFF_STATUS, 32'h0000_0010);
		chk({31'h0, gseen}, 32'h0000_0001);
		chk({31'h0, pseen}, 32'h0000_0001);
		wr(`PFE_OFF_CTRL, 32'h0000_0002);
		rchk(`PFE_OFF_STATE, 32'h0000_0008);
		// second reset, with the core already stopped by the wake write
		rstn <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rstn <= 1'b1;
		rchk(`PFE_OFF_PC, {20'h0_0000, `PFE_RST_PC});
		rchk(`PFE_OFF_CTRL, 32'h0000_0000);
		wrap_up;
	end
endmodule

// [pfe_pkg.sv]
package pfe_pkg;

	typedef enum logic [1:0] {
		PFE_EXEC = 2'b00,
		PFE_WAIT = 2'b01,
		PFE_FETCH = 2'b10,
		PFE_ASLEEP = 2'b11
	} pfe_phase_e;

	typedef struct packed {
		logic [11:0] pc;
		logic [3:0] mode;
		logic [7:0] index;
		logic [7:0] status;
		logic [7:0] acc;
	} pfe_arch_s;

	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] data;
		logic [3:0] strb;
	} pfe_wreq_s;

endpackage
